// File: design/pcss_pkg.sv
// shared constants and types for the port clock source select block
package pcss_pkg;

  // ************************************************************
  // loopback field codes
  // ************************************************************
  localparam logic [2:0] LBM_LINE = 3'h0_2;
  localparam logic [2:0] LBM_PAYLOAD = 3'h0_3;
  localparam logic [2:0] LBM_LINE_DIAG = 3'h0_6;
  localparam int LBM_DIAG_BIT = 2;

  // ************************************************************
  // line mode field codes
  // ************************************************************
  localparam int LM_DISABLE_BIT = 2;
  localparam logic [1:0] LM_LOW_OFF = 2'h0_0;

  // ************************************************************
  // clock source indices into the source vector
  // ************************************************************
  localparam int SRC_RECOVERED = 0;
  localparam int SRC_RX_LINE_IN = 1;
  localparam int SRC_TX_IN = 2;
  localparam int SRC_RATE_BASE = 3;
  localparam int SRC_RESET = SRC_RECOVERED;

  // ************************************************************
  // pin synchroniser depth
  // ************************************************************
  localparam int SYNC_STAGES = 3;

  // ************************************************************
  // clock switch states
  // ************************************************************
  typedef enum logic [1:0]
  {
    SW_FOLLOW = 2'h0_1,
    SW_PARK = 2'h0_2
  } pcss_sw_state_t;

endpackage : pcss_pkg

// File: design/pcss_clock_switch.sv
// glitch-free switch between sampled clock levels
`timescale 1ns/1ps
module pcss_clock_switch #(
  parameter int NUM_SRC = 5,
  parameter int SEL_W = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [NUM_SRC-1:0] srcLevels,
  input wire logic [SEL_W-1:0] selReq,
  output logic clockOut,
  output logic [SEL_W-1:0] selActive,
  output logic busy
);

  // ************************************************************
  // checks
  // ************************************************************
  initial
  begin
    if (NUM_SRC < 2 || (1 << SEL_W) < NUM_SRC)
    begin
      $error("pcss_clock_switch: bad NUM_SRC or SEL_W");
    end
  end

  pcss_pkg::pcss_sw_state_t state_r;
  logic [SEL_W-1:0] cur_r;
  logic out_r;

  // ************************************************************
  // switch: finish old high phase, park low, join new on its low
  // ************************************************************
  // never cuts a high phase short, so no runt pulse on a change
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= pcss_pkg::SW_FOLLOW;
      cur_r <= SEL_W'(pcss_pkg::SRC_RESET);
      out_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        pcss_pkg::SW_FOLLOW:
        begin
          if (selReq != cur_r && !srcLevels[cur_r])
          begin
            state_r <= pcss_pkg::SW_PARK; // RQ23
            out_r <= 1'b0;
          end
          else
          begin
            out_r <= srcLevels[cur_r];
          end
        end
        pcss_pkg::SW_PARK:
        begin
          out_r <= 1'b0;
          if (!srcLevels[selReq])
          begin
            cur_r <= selReq; // RQ23
            state_r <= pcss_pkg::SW_FOLLOW;
          end
        end
        default:
        begin
          state_r <= pcss_pkg::SW_PARK;
          out_r <= 1'b0;
        end
      endcase
    end
  end

  assign clockOut = out_r;
  assign selActive = cur_r;
  assign busy = (state_r != pcss_pkg::SW_FOLLOW) || (selReq != cur_r);

endmodule : pcss_clock_switch

// File: design/pcss_port_clock_select.sv
// per-port clock source selection for receive, transmit and clock pins
//
// What this block does
// RQ1 - loop timing: transmit follows receive, no tx pin
// RQ2 - loop timing: loopbacks never change clock sources
// RQ3 - loop, unit on: recovered clock drives all
// RQ4 - loop, unit off: rx line pin drives all
// RQ5 - no loop timing: loopbacks switch affected sources
// RQ6 - line loopback: tx line clock from receive source
// RQ7 - payload loopback: tx clock from receive source
// RQ8 - payload loopback: ignore transmit framer inputs
// RQ9 - diagnostic loopback: receive clock from transmit source
// RQ10 - diagnostic loopback: ignore receive line signals
// RQ11 - line plus diagnostic: split line and rx clocks
// RQ12 - normal, external select: transmit from tx pin
// RQ13 - normal, no external select: rate adapter clock
// RQ14 - receive default: recovered or rx line pin
// RQ15 - transmit default: rate adapter clocks
// RQ16 - line unit enable decoded from line mode
// RQ17 - no line/payload loop: tx line follows transmit
// RQ18 - far side: loop, unit on, time to rx out
// RQ19 - far side: loop, unit off, time to rx in
// RQ20 - far side: versatile pin timing valid always
// RQ21 - far side: line loopback, time to tx line
// RQ22 - far side: diagnostic loopback, time to rx out (model times line data to rx in instead)
// RQ23 - clock switching free of glitches and runts
`timescale 1ns/1ps
module pcss_port_clock_select #(
  parameter int NUM_RATE_CLOCKS = 2,
  parameter int FRAMER_W = 1,
  parameter int LINE_W = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic loopTimingSelect,
  input wire logic [2:0] loopbackModeField,
  input wire logic [2:0] lineModeField,
  input wire logic externalTxClockSelect,
  input wire logic [((NUM_RATE_CLOCKS > 1) ? $clog2(NUM_RATE_CLOCKS) : 1)-1:0] rateClockIndex,
  input wire logic txClockInPin,
  input wire logic rxLineClockInPin,
  input wire logic recoveredRxLineClock,
  input wire logic [NUM_RATE_CLOCKS-1:0] rateAdapterClocks,
  input wire logic [FRAMER_W-1:0] txFramerData,
  input wire logic [LINE_W-1:0] rxLineData,
  output logic rxClockInternal,
  output logic txClockInternal,
  output logic rxClockOutPin,
  output logic txClockOutPin,
  output logic txLineClockOutPin,
  output logic lineUnitEnabled,
  output logic txFramerInputsIgnored,
  output logic rxLineSignalsIgnored,
  output logic [FRAMER_W-1:0] txFramerDataGated,
  output logic [LINE_W-1:0] rxLineDataGated,
  output logic clockSwitchBusy
);

  // ************************************************************
  // derived widths
  // ************************************************************
  localparam int RATE_W = (NUM_RATE_CLOCKS > 1) ? $clog2(NUM_RATE_CLOCKS) : 1;
  localparam int NUM_SRC = pcss_pkg::SRC_RATE_BASE + NUM_RATE_CLOCKS;
  localparam int SEL_W = $clog2(NUM_SRC);
  localparam int NUM_PIN = NUM_SRC + FRAMER_W + LINE_W;
  localparam int NUM_MUX = 5;
  localparam int MUX_RX = 0;
  localparam int MUX_TX = 1;
  localparam int MUX_RX_OUT = 2;
  localparam int MUX_TX_OUT = 3;
  localparam int MUX_TX_LINE = 4;

  // ************************************************************
  // checks
  // ************************************************************
  initial
  begin
    if (NUM_RATE_CLOCKS < 1 || FRAMER_W < 1 || LINE_W < 1)
    begin
      $error("pcss_port_clock_select: widths and counts must be at least one");
    end
  end

  // ************************************************************
  // mode decode helpers
  // ************************************************************
  function automatic logic isLineLoop(input logic [2:0] lbm);
    isLineLoop = (lbm == pcss_pkg::LBM_LINE) || (lbm == pcss_pkg::LBM_LINE_DIAG);
  endfunction : isLineLoop

  function automatic logic isPayloadLoop(input logic [2:0] lbm);
    isPayloadLoop = (lbm == pcss_pkg::LBM_PAYLOAD);
  endfunction : isPayloadLoop

  function automatic logic isDiagLoop(input logic [2:0] lbm);
    isDiagLoop = lbm[pcss_pkg::LBM_DIAG_BIT];
  endfunction : isDiagLoop

  function automatic logic unitEnableOf(input logic [2:0] lm);
    unitEnableOf = !lm[pcss_pkg::LM_DISABLE_BIT] && (lm[1:0] != pcss_pkg::LM_LOW_OFF);
  endfunction : unitEnableOf

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // clocks are only sampled; an edge is seen a few clk cycles late
  logic [NUM_PIN-1:0] pinRaw;
  logic [NUM_PIN-1:0] pinSync;

  assign pinRaw = {rxLineData, txFramerData, rateAdapterClocks,
                   txClockInPin, rxLineClockInPin, recoveredRxLineClock};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PIN; gi++)
    begin : gSync
      logic [pcss_pkg::SYNC_STAGES-1:0] stage_r;
      logic level_r;
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          stage_r <= '0;
        end
        else
        begin
          stage_r <= {stage_r[pcss_pkg::SYNC_STAGES-2:0], pinRaw[gi]};
        end
      end
      // change taken only once second and third stages agree
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          level_r <= 1'b0;
        end
        else if (stage_r[1] == stage_r[2])
        begin
          level_r <= stage_r[1];
        end
      end
      assign pinSync[gi] = level_r;
    end
  endgenerate

  logic [NUM_SRC-1:0] srcLevels;
  logic [FRAMER_W-1:0] txFramerSync;
  logic [LINE_W-1:0] rxLineSync;

  assign srcLevels = pinSync[NUM_SRC-1:0];
  assign txFramerSync = pinSync[NUM_SRC +: FRAMER_W];
  assign rxLineSync = pinSync[NUM_SRC+FRAMER_W +: LINE_W];

  // ************************************************************
  // source selection
  // ************************************************************
  logic unitOn;
  logic loopOn;
  logic lineLoop;
  logic payloadLoop;
  logic diagLoop;
  logic [RATE_W-1:0] rateIdxSafe;
  logic [SEL_W-1:0] selRxDefault;
  logic [SEL_W-1:0] selTxDefault;
  logic [SEL_W-1:0] selRx;
  logic [SEL_W-1:0] selTx;
  logic [SEL_W-1:0] selTxLine;

  assign unitOn = unitEnableOf(lineModeField); // RQ16
  assign loopOn = loopTimingSelect;
  assign lineLoop = isLineLoop(loopbackModeField);
  assign payloadLoop = isPayloadLoop(loopbackModeField);
  assign diagLoop = isDiagLoop(loopbackModeField);

  // an out-of-range rate index falls back to the first rate clock
  assign rateIdxSafe = (32'(rateClockIndex) < NUM_RATE_CLOCKS) ? rateClockIndex : '0;

  always_comb
  begin
    // receive default: recovered clock or rx line pin
    selRxDefault = unitOn ? SEL_W'(pcss_pkg::SRC_RECOVERED)
                          : SEL_W'(pcss_pkg::SRC_RX_LINE_IN); // RQ14
    // transmit default: rate adapter unless external clock selected
    selTxDefault = externalTxClockSelect ? SEL_W'(pcss_pkg::SRC_TX_IN)
                 : SEL_W'(pcss_pkg::SRC_RATE_BASE + 32'(rateIdxSafe)); // RQ12 RQ13 RQ15
  end

  always_comb
  begin
    selRx = selRxDefault;
    selTx = selTxDefault;
    selTxLine = selTxDefault;
    if (loopOn)
    begin
      // loopback field is not looked at here at all
      selRx = selRxDefault; // RQ2 RQ3 RQ4
      selTx = selRxDefault; // RQ1
      selTxLine = selRxDefault; // RQ3 RQ4
    end
    else
    begin
      // RQ5
      if (payloadLoop)
      begin
        selTx = selRxDefault; // RQ7
      end
      if (diagLoop)
      begin
        selRx = selTxDefault; // RQ9 RQ11
      end
      if (lineLoop || payloadLoop)
      begin
        selTxLine = selRxDefault; // RQ6 RQ11
      end
      else
      begin
        selTxLine = selTxDefault; // RQ17
      end
    end
  end

  // ************************************************************
  // clock switches
  // ************************************************************
  // each output has its own switch so they all stay glitch free;
  // outputs on the same source stay in phase
  logic [SEL_W-1:0] muxSel [NUM_MUX];
  logic [NUM_MUX-1:0] muxClock;
  logic [NUM_MUX-1:0] muxBusy;

  assign muxSel[MUX_RX] = selRx;
  assign muxSel[MUX_TX] = selTx;
  assign muxSel[MUX_RX_OUT] = selRx; // RQ9
  assign muxSel[MUX_TX_OUT] = selTx; // RQ7
  assign muxSel[MUX_TX_LINE] = selTxLine;

  generate
    for (gi = 0; gi < NUM_MUX; gi++)
    begin : gMux
      pcss_clock_switch #(
        .NUM_SRC(NUM_SRC),
        .SEL_W(SEL_W)
      ) uSwitch (
        .clk(clk),
        .sys_rst(sys_rst),
        .srcLevels(srcLevels),
        .selReq(muxSel[gi]),
        .clockOut(muxClock[gi]), // RQ23
        .selActive(),
        .busy(muxBusy[gi])
      );
    end
  endgenerate

  assign rxClockInternal = muxClock[MUX_RX];
  assign txClockInternal = muxClock[MUX_TX];
  assign rxClockOutPin = muxClock[MUX_RX_OUT];
  assign txClockOutPin = muxClock[MUX_TX_OUT];
  assign txLineClockOutPin = muxClock[MUX_TX_LINE];
  assign clockSwitchBusy = |muxBusy;

  // ************************************************************
  // input ignore and gating
  // ************************************************************
  logic unitOn_r;
  logic txIgnore_r;
  logic rxIgnore_r;
  logic [FRAMER_W-1:0] txFramerGated_r;
  logic [LINE_W-1:0] rxLineGated_r;

  // decode registered so the flag lines up with the gated data
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      unitOn_r <= 1'b0;
    end
    else
    begin
      unitOn_r <= unitOn; // RQ16
    end
  end

  // framer inputs ignored in payload loopback, even loop timed
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      txIgnore_r <= 1'b0;
    end
    else
    begin
      txIgnore_r <= payloadLoop; // RQ8
    end
  end

  // any diagnostic code counts, so 101 and 111 also cut the line side
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rxIgnore_r <= 1'b0;
    end
    else
    begin
      rxIgnore_r <= diagLoop; // RQ10
    end
  end

  // gated data is held at zero while ignored
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      txFramerGated_r <= '0;
    end
    else
    begin
      txFramerGated_r <= payloadLoop ? '0 : txFramerSync; // RQ8
    end
  end

  // zero rather than hold, so a stale line sample never leaks through
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rxLineGated_r <= '0;
    end
    else
    begin
      rxLineGated_r <= diagLoop ? '0 : rxLineSync; // RQ10
    end
  end

  assign lineUnitEnabled = unitOn_r;
  assign txFramerInputsIgnored = txIgnore_r;
  assign rxLineSignalsIgnored = rxIgnore_r;
  assign txFramerDataGated = txFramerGated_r;
  assign rxLineDataGated = rxLineGated_r;

endmodule : pcss_port_clock_select

// File: dv/pcss_port_clock_select_sva.sv
// assertion checker for the port clock select block
`timescale 1ns/1ps
module pcss_port_clock_select_sva #(
  parameter int FRAMER_W = 1,
  parameter int LINE_W = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic loopTimingSelect,
  input wire logic [2:0] loopbackModeField,
  input wire logic [2:0] lineModeField,
  input wire logic rxClockInternal,
  input wire logic txClockInternal,
  input wire logic rxClockOutPin,
  input wire logic txClockOutPin,
  input wire logic txLineClockOutPin,
  input wire logic lineUnitEnabled,
  input wire logic txFramerInputsIgnored,
  input wire logic rxLineSignalsIgnored,
  input wire logic [FRAMER_W-1:0] txFramerDataGated,
  input wire logic [LINE_W-1:0] rxLineDataGated,
  input wire logic clockSwitchBusy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ************************************************************
  // settled modes: eight quiet cycles so every switch sits on its source
  // ************************************************************
  sequence s_loop_settled;
    (loopTimingSelect && !clockSwitchBusy)[*8];
  endsequence
  sequence s_payload_settled;
    (!loopTimingSelect && loopbackModeField == 3'h3 && !clockSwitchBusy)[*8];
  endsequence
  sequence s_diag_settled;
    (!loopTimingSelect && loopbackModeField[2] && !clockSwitchBusy)[*8];
  endsequence
  AST_LOOP_SAME: assert property (
    s_loop_settled |-> txClockInternal == rxClockInternal && txClockOutPin == rxClockOutPin
      && txLineClockOutPin == rxClockOutPin) else $error("loop timed clocks differ");
  AST_PAYLOAD_SAME: assert property (
    s_payload_settled |-> txClockInternal == rxClockInternal && txClockOutPin == rxClockOutPin
      && txLineClockOutPin == rxClockOutPin) else $error("payload loop clocks differ");
  AST_DIAG_SAME: assert property (
    s_diag_settled |-> rxClockInternal == txClockInternal && rxClockOutPin == txClockOutPin)
    else $error("diagnostic loop clocks differ");
  AST_TX_NORUNT: assert property ($rose(txClockInternal) |=> txClockInternal[*2])
    else $error("short high phase on tx clock");
  AST_LINE_NORUNT: assert property ($rose(txLineClockOutPin) |=> txLineClockOutPin[*2])
    else $error("short high phase on line clock");
  AST_BUSY_BOUND: assert property ($rose(clockSwitchBusy) |-> ##[1:40] !clockSwitchBusy)
    else $error("clock switch never settles");
  AST_TXIGN: assert property (
    1'b1 |=> txFramerInputsIgnored == ($past(loopbackModeField) == 3'h3))
    else $error("framer ignore flag wrong");
  AST_RXIGN: assert property (
    1'b1 |=> rxLineSignalsIgnored == ($past(loopbackModeField) >= 3'h4))
    else $error("line ignore flag wrong");
  AST_LUE: assert property (
    1'b1 |=> lineUnitEnabled == ($past(lineModeField) inside {3'h1, 3'h2, 3'h3}))
    else $error("line unit enable decode wrong");
  AST_TXGATE: assert property (
    txFramerInputsIgnored && $past(txFramerInputsIgnored) |-> txFramerDataGated == '0)
    else $error("framer data passes while ignored");
  AST_RXGATE: assert property (
    rxLineSignalsIgnored && $past(rxLineSignalsIgnored) |-> rxLineDataGated == '0)
    else $error("line data passes while ignored");
endmodule : pcss_port_clock_select_sva

bind pcss_port_clock_select pcss_port_clock_select_sva #(
  .FRAMER_W(FRAMER_W),
  .LINE_W(LINE_W)
) u_sva (
  .clk, .sys_rst, .loopTimingSelect, .loopbackModeField, .lineModeField,
  .rxClockInternal, .txClockInternal, .rxClockOutPin, .txClockOutPin, .txLineClockOutPin,
  .lineUnitEnabled, .txFramerInputsIgnored, .rxLineSignalsIgnored,
  .txFramerDataGated, .rxLineDataGated, .clockSwitchBusy
);

// File: dv/pcss_far_side_model.sv
// far side model: line, transmit and rate clocks plus data
`timescale 1ns/1ps
module pcss_far_side_model (
  input wire logic [4:0] runMask,
  input wire logic txClockOut,
  input wire logic rxClockOut,
  input wire logic txLineClockOut,
  input wire logic lineToRxOut,
  output logic [4:0] srcClocks,
  output logic [1:0] lineData,
  output logic framerData,
  output logic [3:0] txLineBeats
);
  // ************************************************************
  // clocks stand low while stopped; phases staggered so sources differ
  // ************************************************************
  for (genvar g = 0; g < 5; g++)
  begin : g_src
    initial
    begin
      srcClocks[g] = 1'b0;
      forever
      begin
        wait (runMask[g]);
        #(7 + 40 * g);
        while (runMask[g])
        begin
          srcClocks[g] = 1'b1;
          #100;
          srcClocks[g] = 1'b0;
          #100;
        end
      end
    end
  end
  initial
  begin
    lineData = 2'h0;
    framerData = 1'b0;
    txLineBeats = 4'h0;
  end
  // loop timed with unit on: line signals ride the rx clock output
  always @(negedge (lineToRxOut ? rxClockOut : srcClocks[1])) lineData <= lineData + 2'h1;
  always @(negedge txClockOut) framerData <= ~framerData;
  // line side takes transmit data on the tx line clock output
  always @(negedge txLineClockOut) txLineBeats <= txLineBeats + 4'h1;
endmodule : pcss_far_side_model

// File: dv/tb_top.sv
// self-checking bench for the port clock select block
`timescale 1ns/1ps
module tb_top;
  logic clk, sys_rst, loop_timing_select, ext, rateIdx, counting, framerData, fGated;
  logic rxInt, txInt, rxOut, txOut, txLine, lue, txIgn, rxIgn, busy;
  logic [2:0] lbm, lm;
  logic [4:0] runMask, srcClocks, outs, prevOuts;
  logic [1:0] lineData, lGated;
  logic [3:0] txLineBeats;
  int mismatches, samples_checked;
  int cnt [5];
  assign outs = {txLine, txOut, rxOut, txInt, rxInt};
  pcss_port_clock_select dut (.clk(clk), .sys_rst(sys_rst), .loopTimingSelect(loop_timing_select),
    .loopbackModeField(lbm), .lineModeField(lm), .externalTxClockSelect(ext),
    .rateClockIndex(rateIdx), .txClockInPin(srcClocks[2]), .rxLineClockInPin(srcClocks[1]),
    .recoveredRxLineClock(srcClocks[0]), .rateAdapterClocks(srcClocks[4:3]),
    .txFramerData(framerData), .rxLineData(lineData), .rxClockInternal(rxInt),
    .txClockInternal(txInt), .rxClockOutPin(rxOut), .txClockOutPin(txOut),
    .txLineClockOutPin(txLine), .lineUnitEnabled(lue), .txFramerInputsIgnored(txIgn),
    .rxLineSignalsIgnored(rxIgn), .txFramerDataGated(fGated), .rxLineDataGated(lGated),
    .clockSwitchBusy(busy));
  pcss_far_side_model far (.runMask(runMask), .txClockOut(txOut), .rxClockOut(rxOut),
    .txLineClockOut(txLine), .lineToRxOut(loop_timing_select && (lm inside {3'h1, 3'h2, 3'h3})),
    .srcClocks(srcClocks), .lineData(lineData), .framerData(framerData),
    .txLineBeats(txLineBeats));
  // ************************************************************
  // rising edges seen on each clock output
  // ************************************************************
  always @(posedge clk)
  begin
    prevOuts <= outs;
    for (int i = 0; i < 5; i++)
      cnt[i] <= counting ? cnt[i] + int'(outs[i] & ~prevOuts[i]) : 0;
  end
  function automatic int exp_src(input int o);
    int r;
    int t;
    r = (lm inside {3'h1, 3'h2, 3'h3}) ? 0 : 1;
    t = ext ? 2 : 3 + int'(rateIdx);
    if (loop_timing_select)
      return r;
    if (o == 0 || o == 2)
      return lbm[2] ? t : r;
    if (o == 4)
      return (lbm inside {3'h2, 3'h3, 3'h6}) ? r : t;
    return (lbm == 3'h3) ? r : t;
  endfunction : exp_src
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      mismatches++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // bounded wait; stopped sources sit low so switches must settle
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    while (busy !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 50)
    begin
      mismatches++;
      $display("ERROR %0t switch stuck", $time);
      tally_and_finish();
    end
    repeat (8) @(posedge clk);
  endtask : wait_idle
  // ************************************************************
  // one mode: run each source alone, count edges on every output
  // ************************************************************
  task automatic sweep(input logic l, input logic [2:0] b, input logic [2:0] m,
    input logic e, input logic x, input string name);
    logic [19:0] want;
    logic [19:0] seen;
    logic [3:0] beats0;
    logic [3:0] beatDiff;
    @(posedge clk);
    loop_timing_select <= l;
    lbm <= b;
    lm <= m;
    ext <= e;
    rateIdx <= x;
    wait_idle();
    check(lue, m inside {3'h1, 3'h2, 3'h3});
    check(txIgn, b == 3'h3);
    check(rxIgn, b[2]);
    check(lGated, b[2] ? 2'h0 : lineData);
    check(fGated, (b == 3'h3) ? 1'b0 : framerData);
    for (int s = 0; s < 5; s++)
    begin
      @(posedge clk);
      runMask <= 5'h01 << s;
      counting <= 1'b1;
      beats0 = txLineBeats;
      repeat (64) @(posedge clk);
      runMask <= 5'h00;
      repeat (12) @(posedge clk);
      counting <= 1'b0;
      #1;
      beatDiff = txLineBeats - beats0;
      check(beatDiff, (exp_src(4) == s) ? 4'h8 : 4'h0);
      for (int o = 0; o < 5; o++)
      begin
        want[o*4+:4] = (exp_src(o) == s) ? 4'h8 : 4'h0;
        seen[o*4+:4] = cnt[o][3:0];
      end
      check(seen, want);
    end
    $display("test %s done", name);
  endtask : sweep
  task automatic t_loop_on;
    sweep(1'b1, 3'h2, 3'h1, 1'b1, 1'b0, "loop unit on");
  endtask : t_loop_on
  task automatic t_loop_off;
    sweep(1'b1, 3'h4, 3'h4, 1'b0, 1'b1, "loop unit off");
  endtask : t_loop_off
  task automatic t_norm_ext;
    sweep(1'b0, 3'h0, 3'h1, 1'b1, 1'b0, "normal tx pin");
  endtask : t_norm_ext
  task automatic t_norm_rate;
    sweep(1'b0, 3'h1, 3'h0, 1'b0, 1'b1, "normal rate");
  endtask : t_norm_rate
  task automatic t_line;
    sweep(1'b0, 3'h2, 3'h2, 1'b1, 1'b0, "line loop");
  endtask : t_line
  task automatic t_line_diag;
    sweep(1'b0, 3'h6, 3'h5, 1'b0, 1'b0, "line and diag");
  endtask : t_line_diag
  task automatic t_payload;
    sweep(1'b0, 3'h3, 3'h3, 1'b0, 1'b1, "payload loop");
  endtask : t_payload
  task automatic t_diag;
    sweep(1'b0, 3'h5, 3'h6, 1'b1, 1'b0, "diag loop");
  endtask : t_diag
  task automatic t_diag_all;
    sweep(1'b0, 3'h7, 3'h7, 1'b0, 1'b1, "diag code seven");
  endtask : t_diag_all
  // mode changes with every source running: switches must stay clean
  task automatic t_live_switch;
    @(posedge clk);
    runMask <= 5'h1F;
    lm <= 3'h1;
    for (int k = 0; k < 16; k++)
    begin
      loop_timing_select <= k[3];
      lbm <= k[2:0];
      ext <= k[0];
      repeat (48) @(posedge clk);
    end
    runMask <= 5'h00;
    wait_idle();
    check(busy, 1'b0);
    $display("test live switch done");
  endtask : t_live_switch
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    {sys_rst, loop_timing_select, lbm, lm, ext, rateIdx, runMask, counting} = {1'b1, 15'h0000};
    mismatches = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    check({outs, lue, txIgn, rxIgn}, 8'h00);
    sys_rst <= 1'b0;
    t_loop_on();
    t_loop_off();
    t_norm_ext();
    t_norm_rate();
    t_line();
    t_line_diag();
    t_payload();
    t_diag();
    t_diag_all();
    t_live_switch();
    tally_and_finish();
  end
endmodule : tb_top
